/* src/logic_cluster.sv */
// Ten-cell programmable logic cluster with APB configuration port
////////////////////////////////////////////////////////////////////////////////
module logic_cluster
    import cluster_pkg::*;
(
    input  wire logic                                 clock,
    input  wire logic                                 rst_b,
    input  cluster_pkg::apb_req_t                     apb_req,
    output cluster_pkg::apb_rsp_t                     apb_rsp,
    input  wire logic                                 chip_wide_clear_n,
    input  wire logic [cluster_pkg::ROW_CLOCKS-1:0]   row_clocks,
    input  wire logic [cluster_pkg::LOCAL_LINES-1:0]  local_lines,
    input  wire logic [cluster_pkg::ROUTE_IN-1:0]     routing_in,
    input  wire logic [cluster_pkg::LINK_W-1:0]       left_link_in,
    input  wire logic [cluster_pkg::LINK_W-1:0]       right_link_in,
    input  wire logic                                 carry_in,
    input  wire logic                                 lut_chain_in,
    input  wire logic                                 reg_chain_in,
    output logic      [cluster_pkg::CELLS-1:0]        row_col_out_a,
    output logic      [cluster_pkg::CELLS-1:0]        row_col_out_b,
    output logic      [cluster_pkg::CELLS-1:0]        local_out,
    output logic                                      lut_chain_out,
    output logic                                      reg_chain_out,
    output logic                                      carry_out
);
    import cluster_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic pick_source(input logic [CTRL_SEL_W-1:0]  sel,
                                         input logic [ROW_CLOCKS-1:0]  rows,
                                         input logic [LOCAL_LINES-1:0] lines);
        pick_source = sel[3] ? lines[sel[2:0]] : rows[sel[2:0]];
    endfunction

    function automatic logic ff_next(input ff_type_t kind,
                                     input logic     q,
                                     input logic     j,
                                     input logic     k);
        unique case (kind)
            FF_D:  ff_next = j;
            FF_T:  ff_next = q ^ j;
            FF_JK: ff_next = (j & ~q) | (~k & q);
            FF_SR: ff_next = j | (~k & q);
        endcase
    endfunction

    function automatic logic carry_of(input logic a, input logic b, input logic c);
        carry_of = (a & b) | (c & (a ^ b));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration storage

    logic [CELL_CFG_W-1:0] cell_word  [CELLS];
    logic [ROUTE_W-1:0]    route_word [CELLS];
    logic [CTRL_W-1:0]     ctrl_word;
    logic                  clear_meta;
    logic                  clear_sync;
    logic                  src_one_prev;
    logic                  src_two_prev;
    logic [CELLS-1:0]      q;

    logic                  bus_write;
    logic                  bus_read_ok;
    logic [3:0]            bus_cell;
    logic                  bus_is_cfg;
    logic                  bus_is_route;

    always_comb
    begin
        bus_write    = apb_req.psel & apb_req.penable & apb_req.pwrite;
        bus_cell     = apb_req.paddr[5:2];
        bus_is_cfg   = (apb_req.paddr[7:6] == CELL_CFG_BASE[7:6]) &&
                       (apb_req.paddr[1:0] == 2'b00) && (bus_cell < 4'(CELLS));
        bus_is_route = (apb_req.paddr[7:6] == CELL_ROUTE_BASE[7:6]) &&
                       (apb_req.paddr[1:0] == 2'b00) && (bus_cell < 4'(CELLS));
        bus_read_ok  = bus_is_cfg || bus_is_route ||
                       (apb_req.paddr == CTRL_LO_ADDR) ||
                       (apb_req.paddr == CTRL_HI_ADDR) ||
                       (apb_req.paddr == STATUS_ADDR);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < CELLS; i++)
            begin
                cell_word[i]  <= CELL_CFG_RESET;
                route_word[i] <= ROUTE_RESET;
            end
            ctrl_word <= CTRL_RESET;
        end
        else if (bus_write)
        begin
            if (bus_is_cfg)
                cell_word[bus_cell] <= apb_req.pwdata[CELL_CFG_W-1:0];
            if (bus_is_route)
                route_word[bus_cell] <= apb_req.pwdata[ROUTE_W-1:0];
            if (apb_req.paddr == CTRL_LO_ADDR)
                ctrl_word[31:0] <= apb_req.pwdata;
            if (apb_req.paddr == CTRL_HI_ADDR)
                ctrl_word[CTRL_W-1:32] <= apb_req.pwdata[CTRL_W-33:0];
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error and zero data
    always_comb
    begin
        apb_rsp.pready  = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~bus_read_ok;
        apb_rsp.prdata  = 32'h0000_0000;
        if (bus_is_cfg)
            apb_rsp.prdata = 32'(cell_word[bus_cell]);
        else if (bus_is_route)
            apb_rsp.prdata = 32'(route_word[bus_cell]);
        else if (apb_req.paddr == CTRL_LO_ADDR)
            apb_rsp.prdata = ctrl_word[31:0];
        else if (apb_req.paddr == CTRL_HI_ADDR)
            apb_rsp.prdata = 32'(ctrl_word[CTRL_W-1:32]);
        else if (apb_req.paddr == STATUS_ADDR)
            apb_rsp.prdata = 32'({clear_sync, carry_out, q});
    end

    ////////////////////////////////////////////////////////////////////////////
    // Chip-wide clear synchroniser

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clear_meta <= 1'b0;
            clear_sync <= 1'b0;
        end
        else
        begin
            clear_meta <= chip_wide_clear_n;
            clear_sync <= clear_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cluster-wide control generation

    logic [CTRL_COUNT-1:0] ctl;
    logic                  dual_edge;
    logic                  tick_one;
    logic                  tick_two;

    always_comb
    begin
        for (int k = 0; k < CTRL_COUNT; k++)
            ctl[k] = pick_source(ctrl_word[k*CTRL_SEL_W +: CTRL_SEL_W],
                                 row_clocks, local_lines);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_one_prev <= 1'b0;
            src_two_prev <= 1'b0;
        end
        else
        begin
            src_one_prev <= ctl[CLK_ONE];
            src_two_prev <= ctl[CLK_TWO];
        end
    end

    // Dual-edge use takes the second clock resource for the falling edge
    always_comb
    begin
        dual_edge = ctrl_word[DUAL_EDGE_BIT];
        tick_one  = ctl[CLK_ONE] & ~src_one_prev & ctl[GATE_ONE];
        if (dual_edge)
            tick_two = ~ctl[CLK_ONE] & src_one_prev & ctl[GATE_TWO];
        else
            tick_two = ctl[CLK_TWO] & ~src_two_prev & ctl[GATE_TWO];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cell datapath

    logic [POOL-1:0]  pool;
    logic [3:0]       din      [CELLS];
    logic [CELLS-1:0] lut_res;
    logic [CELLS-1:0] reg_view;
    logic [CELLS-1:0] aclr_hit;
    logic [CELLS-1:0] tick;
    logic [CELLS-1:0] reg_d;
    ff_type_t         ff_kind  [CELLS];
    logic [CELLS:0]   carry_zero;
    logic [CELLS:0]   carry_one;
    logic             carry_sel;

    // Own cells feed the input pool through their registers, avoiding loops
    assign pool = {right_link_in, left_link_in, q, routing_in};

    always_comb
    begin
        cell_cfg_t cfg;
        logic      a;
        logic      b;
        logic      dd;
        logic      cin;
        a             = 1'b0;
        b             = 1'b0;
        dd            = 1'b0;
        cin           = 1'b0;
        cfg           = cell_cfg_t'(cell_word[0]);
        carry_zero[0] = 1'b0;
        carry_one[0]  = 1'b1;
        carry_sel     = carry_in | (cfg.arith & ctl[ADDSUB]);
        for (int i = 0; i < CELLS; i++)
        begin
            cfg = cell_cfg_t'(cell_word[i]);
            for (int j = 0; j < 4; j++)
                din[i][j] = pool[route_word[i][j*POOL_SEL_W +: POOL_SEL_W]];
            if (cfg.lut_chain)
                a = (i == 0) ? lut_chain_in : lut_res[(i == 0) ? 0 : i-1];
            else
                a = din[i][0];
            dd = cfg.pack ? q[i] : din[i][3];
            b  = din[i][1] ^ (cfg.arith & ctl[ADDSUB]);
            cin = carry_sel ? carry_one[i] : carry_zero[i];
            if (cfg.arith)
            begin
                lut_res[i]      = a ^ b ^ cin;
                carry_zero[i+1] = carry_of(a, b, carry_zero[i]);
                carry_one[i+1]  = carry_of(a, b, carry_one[i]);
            end
            else
            begin
                lut_res[i]      = cfg.mask[{dd, din[i][2], din[i][1], a}];
                carry_zero[i+1] = carry_zero[i];
                carry_one[i+1]  = carry_one[i];
            end
            aclr_hit[i] = cfg.aclr_two ? ctl[ACLR_TWO] : ctl[ACLR_ONE];
            tick[i]     = cfg.clock_two ? tick_two : tick_one;
            ff_kind[i]  = cfg.ff_type;
            if (cfg.reg_chain)
                reg_d[i] = (i == 0) ? reg_chain_in : q[(i == 0) ? 0 : i-1];
            else
                reg_d[i] = lut_res[i];
        end
        carry_out = carry_sel ? carry_one[CELLS] : carry_zero[CELLS];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cell registers

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
        begin
            for (int i = 0; i < CELLS; i++)
            begin
                if (!clear_sync)
                    q[i] <= 1'b0;
                else if (aclr_hit[i])
                    q[i] <= 1'b0;
                else if (ctl[ALOAD])
                    q[i] <= din[i][2];
                else if (tick[i])
                begin
                    if (ctl[SCLR])
                        q[i] <= 1'b0;
                    else if (ctl[SLOAD])
                        q[i] <= din[i][2];
                    else
                        q[i] <= ff_next(ff_kind[i], q[i], reg_d[i], din[i][3]);
                end
            end
        end
    end

    // Asynchronous controls reach the register view without waiting a clock
    always_comb
    begin
        for (int i = 0; i < CELLS; i++)
        begin
            if (!clear_sync || aclr_hit[i])
                reg_view[i] = 1'b0;
            else if (ctl[ALOAD])
                reg_view[i] = din[i][2];
            else
                reg_view[i] = q[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cell outputs

    always_comb
    begin
        for (int i = 0; i < CELLS; i++)
        begin
            cell_cfg_t cfg;
            cfg = cell_cfg_t'(cell_word[i]);
            row_col_out_a[i] = cfg.out_sel[0] ? reg_view[i] : lut_res[i];
            row_col_out_b[i] = cfg.out_sel[1] ? reg_view[i] : lut_res[i];
            local_out[i]     = cfg.out_sel[2] ? reg_view[i] : lut_res[i];
        end
        lut_chain_out = lut_res[CELLS-1];
        reg_chain_out = q[CELLS-1];
    end

endmodule // logic_cluster

/* src/cluster_pkg.sv */
// Shared constants, types and register map of the logic cluster
package cluster_pkg;

    localparam int CELLS       = 10;
    localparam int ROW_CLOCKS  = 8;
    localparam int LOCAL_LINES = 8;
    localparam int ROUTE_IN    = 12;
    localparam int LINK_W      = 5;
    localparam int POOL        = 32;
    localparam int POOL_SEL_W  = 5;
    localparam int CTRL_COUNT  = 10;
    localparam int CTRL_SEL_W  = 4;

    // Register byte offsets
    localparam logic [7:0] CELL_CFG_BASE   = 8'h00;
    localparam logic [7:0] CELL_ROUTE_BASE = 8'h40;
    localparam logic [7:0] CTRL_LO_ADDR    = 8'h80;
    localparam logic [7:0] CTRL_HI_ADDR    = 8'h84;
    localparam logic [7:0] STATUS_ADDR     = 8'h88;

    // Field layout and reset values
    localparam int CELL_CFG_W  = 27;
    localparam int ROUTE_W     = 20;
    localparam int CTRL_W      = 41;
    localparam int DUAL_EDGE_BIT = 40;
    localparam logic [CELL_CFG_W-1:0] CELL_CFG_RESET = 27'h000_0000;
    localparam logic [ROUTE_W-1:0]    ROUTE_RESET    = 20'h0_0000;
    localparam logic [CTRL_W-1:0]     CTRL_RESET     = 41'h000_0000_0000;

    // Cluster-wide control signal indices
    localparam int CLK_ONE   = 0;
    localparam int CLK_TWO   = 1;
    localparam int GATE_ONE  = 2;
    localparam int GATE_TWO  = 3;
    localparam int ACLR_ONE  = 4;
    localparam int ACLR_TWO  = 5;
    localparam int SCLR      = 6;
    localparam int ALOAD     = 7;
    localparam int SLOAD     = 8;
    localparam int ADDSUB    = 9;

    typedef enum logic [1:0] {
        FF_D  = 2'b00,
        FF_T  = 2'b01,
        FF_JK = 2'b10,
        FF_SR = 2'b11
    } ff_type_t;

    typedef struct packed {
        logic            lut_chain;
        logic            reg_chain;
        logic            pack;
        logic [2:0]      out_sel;
        ff_type_t        ff_type;
        logic            aclr_two;
        logic            clock_two;
        logic            arith;
        logic [15:0]     mask;
    } cell_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage

/* tb/cluster_props.sv */
// Port checker for the logic cluster
module cluster_props
    import cluster_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        rst_b,
    input  cluster_pkg::apb_req_t            apb_req,
    input  cluster_pkg::apb_rsp_t            apb_rsp,
    input  wire logic                        chip_wide_clear_n,
    input  wire logic                        carry_in,
    input  wire logic [cluster_pkg::CELLS-1:0] local_out,
    input  wire logic                        reg_chain_out,
    input  wire logic                        carry_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic       acc;
    logic       rd;
    logic       hit;
    logic [7:0] a;
    assign a   = apb_req.paddr;
    assign acc = apb_req.psel && apb_req.penable;
    assign rd  = acc && !apb_req.pwrite;
    assign hit = (a[1:0] == 2'b00) && (a < 8'h28 || (a >= 8'h40 && a < 8'h68)
                 || (a >= 8'h80 && a < 8'h8c));
    ////////////////////////////////////////
    a_ready_always: assert property (acc |-> apb_rsp.pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && !hit |-> apb_rsp.pslverr && apb_rsp.prdata == 0)
        else $error("unmapped access not refused");
    a_mapped_clean: assert property (acc && hit |-> !apb_rsp.pslverr)
        else $error("mapped access refused");
    a_status_mirror: assert property (rd && a == STATUS_ADDR |-> apb_rsp.prdata[9] == reg_chain_out
        && apb_rsp.prdata[10] == carry_out && apb_rsp.prdata[31:12] == 0)
        else $error("status word differs from outputs");
    a_cfg_width: assert property (rd && hit && a < 8'h28 |-> apb_rsp.prdata[31:27] == 0)
        else $error("cell config upper bits set");
    a_route_width: assert property (rd && hit && a[7:6] == 2'b01 |-> apb_rsp.prdata[31:20] == 0)
        else $error("routing upper bits set");
    a_ctrl_width: assert property (rd && a == CTRL_HI_ADDR |-> apb_rsp.prdata[31:9] == 0)
        else $error("control high upper bits set");
    a_reset_idle: assert property ($rose(rst_b) |-> local_out == 0 && carry_out == carry_in)
        else $error("outputs not idle after reset");
    a_chip_clear: assert property (!chip_wide_clear_n [*5] |-> !reg_chain_out)
        else $error("register survives chip clear");
    cover property (acc && apb_rsp.pslverr);
    cover property ($rose(reg_chain_out));
    cover property ($rose(carry_out));
endmodule // cluster_props

bind logic_cluster cluster_props cluster_props_i (.clock(clock), .rst_b(rst_b),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .chip_wide_clear_n(chip_wide_clear_n),
    .carry_in(carry_in), .local_out(local_out), .reg_chain_out(reg_chain_out),
    .carry_out(carry_out));

/* tb/fabric_model.sv */
// Routing fabric and neighbour cluster model
module fabric_model
    import cluster_pkg::*;
(
    input  wire logic                              clock,
    input  wire logic                              rst_b,
    input  wire logic                              tick_req,
    input  wire logic [cluster_pkg::LOCAL_LINES-1:0] lines_set,
    input  wire logic [cluster_pkg::ROUTE_IN-1:0]  route_set,
    output logic      [cluster_pkg::ROW_CLOCKS-1:0] row_clocks,
    output logic      [cluster_pkg::LOCAL_LINES-1:0] local_lines,
    output logic      [cluster_pkg::ROUTE_IN-1:0]  routing_in,
    output logic      [cluster_pkg::LINK_W-1:0]    left_link_in,
    output logic      [cluster_pkg::LINK_W-1:0]    right_link_in,
    output logic                                   carry_in,
    output logic                                   lut_chain_in,
    output logic                                   reg_chain_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [LINK_W-1:0] churn;
    assign local_lines  = lines_set;
    assign routing_in   = route_set;
    // Unselected neighbour links keep changing so a wrong pick shows up
    assign left_link_in  = churn;
    assign right_link_in = ~churn;
    assign carry_in     = 1'b0;
    assign lut_chain_in = churn[0];
    assign reg_chain_in = churn[1];
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            row_clocks <= '0;
            churn      <= '0;
        end
        else
        begin
            row_clocks <= {7'h00, tick_req};
            churn      <= churn + 5'h01;
        end
    end
endmodule // fabric_model

/* tb/test_logic_cluster.sv */
// Self-checking bench for the logic cluster
module test_logic_cluster
    import cluster_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        chip_wide_clear_n = 1'b1;
    logic        tick_req = 1'b0;
    logic [7:0]  lines_set = 8'h00;
    logic [11:0] route_set = 12'h000;
    apb_req_t    apb_req = '0;
    apb_rsp_t    apb_rsp;
    logic [7:0]  row_clocks;
    logic [7:0]  local_lines;
    logic [11:0] routing_in;
    logic [4:0]  left_link_in;
    logic [4:0]  right_link_in;
    logic        carry_in;
    logic        lut_chain_in;
    logic        reg_chain_in;
    logic [9:0]  row_col_out_a;
    logic [9:0]  row_col_out_b;
    logic [9:0]  local_out;
    logic        lut_chain_out;
    logic        reg_chain_out;
    logic        carry_out;
    logic [31:0] rdata;
    logic        err;
    int          err_total = 0;
    int          check_count = 0;

    always #5 clock = ~clock;

    logic_cluster logic_cluster_i (.clock, .rst_b, .apb_req, .apb_rsp, .chip_wide_clear_n,
        .row_clocks, .local_lines, .routing_in, .left_link_in, .right_link_in, .carry_in,
        .lut_chain_in, .reg_chain_in, .row_col_out_a, .row_col_out_b, .local_out,
        .lut_chain_out, .reg_chain_out, .carry_out);
    fabric_model fabric_model_i (.clock, .rst_b, .tick_req, .lines_set, .route_set,
        .row_clocks, .local_lines, .routing_in, .left_link_in, .right_link_in, .carry_in,
        .lut_chain_in, .reg_chain_in);
    ////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clock);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        @(posedge clock);
        for (n = 0; apb_rsp.pready !== 1'b1; n++)
        begin
            if (n == 50)
            begin
                err_total++;
                finish_test();
            end
            @(posedge clock);
        end
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0000_0000);
        check_word(rdata, exp);
    endtask
    task automatic drive(input logic [7:0] l, input logic [11:0] r);
        @(posedge clock);
        lines_set <= l;
        route_set <= r;
        @(posedge clock);
        #1;
    endtask
    // One rising pulse on row clock zero
    task automatic tick();
        @(posedge clock);
        tick_req <= 1'b1;
        @(posedge clock);
        tick_req <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask
    ////////////////////////////////////////
    task automatic test_regs();
        rd_chk(CELL_CFG_BASE, 32'h0000_0000);
        rd_chk(CTRL_LO_ADDR, 32'h0000_0000);
        apb(1'b1, 8'h24, 32'hFFFF_FFFF);
        rd_chk(8'h24, 32'h07FF_FFFF);
        apb(1'b1, 8'h64, 32'hFFFF_FFFF);
        rd_chk(8'h64, 32'h000F_FFFF);
        apb(1'b1, CTRL_HI_ADDR, 32'hFFFF_FFFF);
        rd_chk(CTRL_HI_ADDR, 32'h0000_01FF);
        rd_chk(8'h8C, 32'h0000_0000);
        check_bit(err, 1'b1);
        apb(1'b1, 8'h02, 32'hFFFF_FFFF);
        check_bit(err, 1'b1);
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b1, 8'h64, 32'h0000_0000);
        $display("test_regs done");
    endtask
    task automatic test_lut();
        logic [15:0] m;
        m = 16'h6996;
        apb(1'b1, CELL_ROUTE_BASE, 32'h0001_8820);
        apb(1'b1, CELL_CFG_BASE, {16'h0000, m});
        for (int v = 0; v < 16; v++)
        begin
            drive(8'h00, 12'(v));
            check_word({row_col_out_a[0], row_col_out_b[0], local_out[0]}, {3{m[v]}});
        end
        apb(1'b1, 8'h04, 32'h0400_AAAA);
        drive(8'h00, 12'h002);
        check_bit(row_col_out_a[1], 1'b1);
        drive(8'h00, 12'h003);
        check_bit(row_col_out_a[1], 1'b0);
        $display("test_lut done");
    endtask
    task automatic test_shift();
        apb(1'b1, 8'h20, 32'h00E0_AAAA);
        apb(1'b1, 8'h24, 32'h0280_0001);
        drive(8'h01, 12'h001);
        tick();
        check_word(local_out[9:8], 32'h0000_0001);
        drive(8'h01, 12'h000);
        tick();
        check_word(local_out[9:8], 32'h0000_0002);
        check_bit(reg_chain_out, 1'b1);
        check_bit(row_col_out_a[9], 1'b1);
        check_bit(lut_chain_out, 1'b1);
        $display("test_shift done");
    endtask
    task automatic test_async();
        apb(1'b1, 8'h24, 32'h00E0_AAAA);
        drive(8'h00, 12'h000);
        tick();
        check_word(local_out[9:8], 32'h0000_0002);
        drive(8'h10, 12'h001);
        check_word(local_out[9:8], 32'h0000_0003);
        drive(8'h12, 12'h001);
        check_word(local_out[9:8], 32'h0000_0000);
        drive(8'h10, 12'h001);
        drive(8'h09, 12'h001);
        tick();
        check_word(local_out[9:8], 32'h0000_0000);
        drive(8'h10, 12'h001);
        drive(8'h00, 12'h001);
        check_word(local_out[9:8], 32'h0000_0003);
        chip_wide_clear_n <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
        check_word(local_out[9:8], 32'h0000_0000);
        chip_wide_clear_n <= 1'b1;
        repeat (4) @(posedge clock);
        $display("test_async done");
    endtask
    task automatic test_arith();
        logic [9:0]  av [5] = '{10'h3FF, 10'h3FF, 10'h001, 10'h000, 10'h3FF};
        logic [4:0]  bs = 5'b11010;
        logic [4:0]  sb = 5'b11100;
        logic [10:0] s;
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b1, 8'(4 * i), 32'h0001_0000);
            apb(1'b1, 8'(8'h40 + 4 * i), 32'h0000_0140 + 32'(i));
        end
        for (int k = 0; k < 5; k++)
        begin
            s = {1'b0, av[k]} + {1'b0, {10{bs[k] ^ sb[k]}}} + {10'h000, sb[k]};
            drive({1'b0, sb[k], 6'h00}, {1'b0, bs[k], av[k]});
            check_bit(carry_out, s[10]);
            check_word(local_out, s[9:0]);
            rd_chk(STATUS_ADDR, {20'h0_0000, 1'b1, s[10], 10'h000});
        end
        $display("test_arith done");
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        test_regs();
        apb(1'b1, CTRL_LO_ADDR, 32'hCBA9_F810);
        apb(1'b1, CTRL_HI_ADDR, 32'h0000_00ED);
        test_lut();
        test_shift();
        test_async();
        test_arith();
        finish_test();
    end
endmodule // test_logic_cluster
